// File: src/spcrc_pkg.sv
// package: scratchpad block checker constants and shared types
package spcrc_pkg;

  // ------------------------------------------------------------
  // sector layout
  // ------------------------------------------------------------
  localparam int unsigned SPCRC_OFFS_W = 12;
  localparam logic [11:0] SPCRC_OFF_FIRST = 12'h000;
  localparam logic [9:0] SPCRC_WORD_HDR = 10'h000;
  localparam logic [9:0] SPCRC_WORD_CRC = 10'h001;
  localparam logic [9:0] SPCRC_WORD_SIZE = 10'h002;
  localparam logic [9:0] SPCRC_WORD_VER = 10'h003;
  localparam logic [11:0] SPCRC_OFF_VER = 12'h00c;
  localparam logic [11:0] SPCRC_OFF_USER = 12'h010;
  localparam logic [11:0] SPCRC_OFF_LAST = 12'hfff;
  localparam logic [11:0] SPCRC_OFF_STEP = 12'h001;

  // ------------------------------------------------------------
  // header values
  // ------------------------------------------------------------
  localparam logic [23:0] SPCRC_SIG = 24'h4d454f;
  localparam logic [31:0] SPCRC_SIZE_VAL = 32'h00000ff4;
  localparam logic [7:0] SPCRC_BLK_MAX = 8'h03;

  // ------------------------------------------------------------
  // crc
  // ------------------------------------------------------------
  localparam logic [31:0] SPCRC_POLY = 32'h04c11db7;
  localparam logic [31:0] SPCRC_INIT = 32'hffffffff;

  // ------------------------------------------------------------
  // buffering
  // ------------------------------------------------------------
  localparam int unsigned SPCRC_FIFO_DEPTH = 8;
  localparam int unsigned SPCRC_BYTE_W = 8;

  typedef struct packed {
    logic [15:0] patch;
    logic [7:0] minor;
    logic [7:0] major;
  } spcrc_ver_t;

  typedef struct packed {
    logic sig_err;
    logic size_err;
    logic blk_err;
    logic ver_err;
    logic crc_err;
  } spcrc_flags_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } spcrc_byte_t;

endpackage : spcrc_pkg

// File: src/spcrc_fifo.sv
// byte fifo sitting in front of the checker
`timescale 1ns/1ps
module spcrc_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // fill side
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  // drain side
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } spcrc_fifo_st_t;

  spcrc_fifo_st_t r_reg;
  spcrc_fifo_st_t r_next;
  logic push;
  logic pop;

  assign push = in_valid_in && !r_reg.full;
  assign pop = out_ready_in && !r_reg.empty;

  always_comb begin
    r_next = r_reg;
    if (push) begin
      r_next.mem[r_reg.wp] = in_data_in;
      r_next.wp = r_reg.wp + AW'(1);
    end
    if (pop) begin
      r_next.rp = r_reg.rp + AW'(1);
    end
    r_next.cnt = r_reg.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    r_next.full = (r_next.cnt == FULL_CNT);
    r_next.empty = (r_next.cnt == '0);
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= '{empty: 1'b1, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign in_ready_out = !r_reg.full;
  assign out_valid_out = !r_reg.empty;
  assign out_data_out = r_reg.mem[r_reg.rp];

endmodule : spcrc_fifo

// File: src/spcrc_checker.sv
// scratchpad sector parser and crc-32 checker
`timescale 1ns/1ps
module spcrc_checker
  import spcrc_pkg::*;
(
  // clock and reset
  input wire logic clock_in,
  input wire logic resetn_in,
  // sector byte source
  input wire spcrc_byte_t src_byte_in,
  output logic src_ready_out,
  // expected structure version and block select
  input wire spcrc_ver_t exp_ver_in,
  input wire logic [1:0] sel_block_in,
  // custom data pass-through
  output spcrc_byte_t user_byte_out,
  input wire logic user_ready_in,
  // result
  output logic busy_out,
  output logic done_out,
  output spcrc_flags_t flags_out,
  output logic [7:0] block_num_out,
  output logic sel_match_out
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // msb-first, no reflection on either side
  function automatic logic [31:0] spcrc_crc_byte(
    input logic [31:0] crc,
    input logic [7:0] b
  );
    logic [31:0] c;
    c = crc ^ {b, 24'h000000};
    for (int i = 0; i < 8; i++) begin
      c = c[31] ? ({c[30:0], 1'b0} ^ SPCRC_POLY) : {c[30:0], 1'b0};
    end
    return c;
  endfunction : spcrc_crc_byte

  // lowest address lands in the lowest lane
  function automatic logic [31:0] spcrc_put_lane(
    input logic [31:0] w,
    input logic [1:0] lane,
    input logic [7:0] b
  );
    logic [31:0] o;
    o = w;
    o[8*lane +: 8] = b;
    return o;
  endfunction : spcrc_put_lane

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic [11:0] offs;
    logic [31:0] crc;
    logic [31:0] hdr;
    logic [31:0] stored_crc;
    logic [31:0] size;
    spcrc_ver_t ver;
    spcrc_byte_t ubyte;
    logic done;
    spcrc_flags_t flags;
    logic [7:0] blk;
    logic match;
  } spcrc_st_t;

  spcrc_st_t r_reg;
  spcrc_st_t r_next;

  logic fifo_valid;
  logic [7:0] fifo_data;
  logic pop;
  logic [31:0] crc_upd;

  // ------------------------------------------------------------
  // input buffer
  // ------------------------------------------------------------
  spcrc_fifo #(
    .WIDTH(SPCRC_BYTE_W),
    .DEPTH(SPCRC_FIFO_DEPTH)
  ) u_fifo (
    .clock_in(clock_in),
    .resetn_in(resetn_in),
    .in_valid_in(src_byte_in.valid),
    .in_data_in(src_byte_in.data),
    .in_ready_out(src_ready_out),
    .out_valid_out(fifo_valid),
    .out_data_out(fifo_data),
    .out_ready_in(pop)
  );

  // stall whole parse while a custom byte waits downstream
  assign pop = fifo_valid && (!r_reg.ubyte.valid || user_ready_in);
  assign crc_upd = spcrc_crc_byte(r_reg.crc, fifo_data);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    if (r_reg.ubyte.valid && user_ready_in) begin
      r_next.ubyte.valid = 1'b0;
    end
    if (pop) begin
      // 12-bit offset wraps at the sector end
      r_next.offs = r_reg.offs + SPCRC_OFF_STEP;
      if (r_reg.offs == SPCRC_OFF_FIRST) begin
        r_next.busy = 1'b1;
        r_next.crc = SPCRC_INIT;
        r_next.flags = '0;
        r_next.match = 1'b0;
      end
      case (r_reg.offs[11:2])
        SPCRC_WORD_HDR: begin
          r_next.hdr = spcrc_put_lane(r_reg.hdr, r_reg.offs[1:0], fifo_data);
        end
        SPCRC_WORD_CRC: begin
          r_next.stored_crc = spcrc_put_lane(r_reg.stored_crc, r_reg.offs[1:0], fifo_data);
        end
        SPCRC_WORD_SIZE: begin
          r_next.size = spcrc_put_lane(r_reg.size, r_reg.offs[1:0], fifo_data);
        end
        SPCRC_WORD_VER: begin
          r_next.ver = spcrc_put_lane(r_reg.ver, r_reg.offs[1:0], fifo_data);
        end
        default: begin
          r_next.ubyte.data = fifo_data;
          r_next.ubyte.valid = 1'b1;
        end
      endcase
      // bytes in address order equal the byte-reversed words msb first
      if (r_reg.offs >= SPCRC_OFF_VER) begin
        r_next.crc = crc_upd;
      end
      if (r_reg.offs == SPCRC_OFF_LAST) begin
        r_next.busy = 1'b0;
        r_next.done = 1'b1;
        r_next.blk = r_reg.hdr[31:24];
        r_next.flags.sig_err = (r_reg.hdr[23:0] != SPCRC_SIG);
        r_next.flags.size_err = (r_reg.size != SPCRC_SIZE_VAL);
        r_next.flags.blk_err = (r_reg.hdr[31:24] > SPCRC_BLK_MAX);
        r_next.flags.ver_err = (r_reg.ver != exp_ver_in);
        // raw register, no final inversion
        r_next.flags.crc_err = (crc_upd != r_reg.stored_crc);
        r_next.match = (r_reg.hdr[31:24] == {6'h00, sel_block_in});
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign user_byte_out = r_reg.ubyte;
  assign busy_out = r_reg.busy;
  assign done_out = r_reg.done;
  assign flags_out = r_reg.flags;
  assign block_num_out = r_reg.blk;
  assign sel_match_out = r_reg.match;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  sequence s_last_pop;
    pop && (r_reg.offs == SPCRC_OFF_LAST);
  endsequence

  sequence s_first_pop;
    pop && (r_reg.offs == SPCRC_OFF_FIRST);
  endsequence

  property p_done_after_last;
    done_out |-> $past(pop && (r_reg.offs == SPCRC_OFF_LAST));
  endproperty
  a_done_after_last: assert property (p_done_after_last)
    else $error("done without last sector byte");

  property p_done_pulse;
    s_last_pop |=> done_out ##1 !done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done is not a single pulse");

  property p_preset;
    s_first_pop |=> (r_reg.crc == SPCRC_INIT);
  endproperty
  a_preset: assert property (p_preset)
    else $error("crc not preset at block start");

  property p_header_excluded;
    pop && (r_reg.offs < SPCRC_OFF_VER) && busy_out |=> (r_reg.crc == SPCRC_INIT);
  endproperty
  a_header_excluded: assert property (p_header_excluded)
    else $error("header word entered crc");

  property p_crc_step;
    logic [31:0] c;
    logic [7:0] b;
    (pop && (r_reg.offs >= SPCRC_OFF_VER), c = r_reg.crc, b = fifo_data)
      |=> (r_reg.crc == spcrc_crc_byte(c, b));
  endproperty
  a_crc_step: assert property (p_crc_step)
    else $error("crc step wrong");

  property p_size_flag;
    s_last_pop |=> (flags_out.size_err == (r_reg.size != SPCRC_SIZE_VAL));
  endproperty
  a_size_flag: assert property (p_size_flag)
    else $error("size flag wrong");

  property p_blk_flag;
    done_out |-> (flags_out.blk_err == (block_num_out > SPCRC_BLK_MAX));
  endproperty
  a_blk_flag: assert property (p_blk_flag)
    else $error("block number flag wrong");

  property p_sig_flag;
    s_last_pop |=> (flags_out.sig_err == (r_reg.hdr[23:0] != SPCRC_SIG));
  endproperty
  a_sig_flag: assert property (p_sig_flag)
    else $error("signature flag wrong");

  property p_ver_flag;
    s_last_pop |=> (flags_out.ver_err == ($past(exp_ver_in) != r_reg.ver));
  endproperty
  a_ver_flag: assert property (p_ver_flag)
    else $error("version flag wrong");

  property p_crc_flag;
    s_last_pop |=> (flags_out.crc_err == (r_reg.crc != r_reg.stored_crc));
  endproperty
  a_crc_flag: assert property (p_crc_flag)
    else $error("crc flag wrong");

  property p_flags_hold;
    !(pop && ((r_reg.offs == SPCRC_OFF_LAST) || (r_reg.offs == SPCRC_OFF_FIRST))) |=> $stable(flags_out);
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flags changed mid block");

  property p_pass;
    logic [7:0] b;
    (pop && (r_reg.offs >= SPCRC_OFF_USER), b = fifo_data)
      |=> user_byte_out.valid && (user_byte_out.data == b);
  endproperty
  a_pass: assert property (p_pass)
    else $error("custom byte not passed through");

  property p_user_hold;
    user_byte_out.valid && !user_ready_in |=> user_byte_out.valid && $stable(user_byte_out.data);
  endproperty
  a_user_hold: assert property (p_user_hold)
    else $error("custom byte dropped under stall");

  property p_match;
    done_out |-> (sel_match_out == (block_num_out == {6'h00, $past(sel_block_in)}));
  endproperty
  a_match: assert property (p_match)
    else $error("block select match wrong");

  property p_busy_start;
    s_first_pop |=> busy_out;
  endproperty
  a_busy_start: assert property (p_busy_start)
    else $error("busy not raised at block start");

  property p_busy_end;
    s_last_pop |=> !busy_out;
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("busy not dropped after last byte");

  property p_flags_clear;
    s_first_pop |=> (flags_out == '0);
  endproperty
  a_flags_clear: assert property (p_flags_clear)
    else $error("flags not cleared at block start");

  property p_done_busy;
    done_out |-> !busy_out;
  endproperty
  a_done_busy: assert property (p_done_busy)
    else $error("done while still busy");

  // offset is the only thing that tracks position, so it must never skip
  property p_offs_step;
    pop |=> (r_reg.offs == $past(r_reg.offs) + SPCRC_OFF_STEP);
  endproperty
  a_offs_step: assert property (p_offs_step)
    else $error("offset did not step by one byte");

  property p_offs_hold;
    !pop |=> $stable(r_reg.offs);
  endproperty
  a_offs_hold: assert property (p_offs_hold)
    else $error("offset moved without a byte");

  property p_crc_hold;
    !pop |=> $stable(r_reg.crc);
  endproperty
  a_crc_hold: assert property (p_crc_hold)
    else $error("crc moved without a byte");

  property p_blk_capture;
    s_last_pop |=> (block_num_out == r_reg.hdr[31:24]);
  endproperty
  a_blk_capture: assert property (p_blk_capture)
    else $error("block number not taken from header");

  property p_user_stall;
    user_byte_out.valid && !user_ready_in |-> !pop;
  endproperty
  a_user_stall: assert property (p_user_stall)
    else $error("byte popped while custom byte waits");

  // lane checks: each stored crc, size and version byte lands where its offset says
  property p_crc_lane;
    logic [7:0] b;
    logic [1:0] l;
    (pop && (r_reg.offs[11:2] == SPCRC_WORD_CRC), b = fifo_data, l = r_reg.offs[1:0])
      |=> (r_reg.stored_crc[8*l +: 8] == b);
  endproperty
  a_crc_lane: assert property (p_crc_lane)
    else $error("stored crc byte in wrong lane");

  property p_size_lane;
    logic [7:0] b;
    logic [1:0] l;
    (pop && (r_reg.offs[11:2] == SPCRC_WORD_SIZE), b = fifo_data, l = r_reg.offs[1:0])
      |=> (r_reg.size[8*l +: 8] == b);
  endproperty
  a_size_lane: assert property (p_size_lane)
    else $error("size byte in wrong lane");

  property p_ver_lane;
    logic [7:0] b;
    logic [1:0] l;
    (pop && (r_reg.offs[11:2] == SPCRC_WORD_VER), b = fifo_data, l = r_reg.offs[1:0])
      |=> (r_reg.ver[8*l +: 8] == b);
  endproperty
  a_ver_lane: assert property (p_ver_lane)
    else $error("version byte in wrong lane");

endmodule : spcrc_checker

// File: verification/spcrc_src_model.sv
// flash read path model streaming one scratchpad sector per start pulse
`timescale 1ns/1ps
module spcrc_src_model
  import spcrc_pkg::*;
(
  // clock, reset, control
  input wire logic clock_in,
  input wire logic resetn_in,
  input wire logic start_in,
  input wire logic gap_in,
  // sector content
  input wire logic [7:0] blk_in,
  input wire logic sig_bad_in,
  input wire logic [31:0] size_in,
  input wire spcrc_ver_t ver_in,
  input wire logic [31:0] crc_mask_in,
  // byte stream
  output spcrc_byte_t src_byte_out,
  input wire logic src_ready_in
);
  logic [7:0] mem [4096];
  logic [12:0] idx;
  logic [12:0] nxt;
  logic [31:0] crc;
  logic hole;

  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[30:0], 1'b0} ^ ((r[31] ^ b[i]) ? SPCRC_POLY : 32'h0);
    return r;
  endfunction : crc_step

  // ------------------------------------------------------------
  // sector image
  // ------------------------------------------------------------
  always @(posedge start_in) begin
    for (int i = 0; i < 4096; i++)
      mem[i] = (i < 256) ? i[7:0] : 8'hff;
    {mem[3], mem[2], mem[1], mem[0]} = {blk_in, 8'h4d, sig_bad_in ? 8'h46 : 8'h45, 8'h4f};
    {mem[11], mem[10], mem[9], mem[8]} = size_in;
    {mem[15], mem[14], mem[13], mem[12]} = ver_in;
    crc = SPCRC_INIT;
    // reversed words fed msb first equal plain address order
    for (int i = 12; i < 4096; i++)
      crc = crc_step(crc, mem[i]);
    {mem[7], mem[6], mem[5], mem[4]} = crc ^ crc_mask_in;
  end

  // ------------------------------------------------------------
  // stream, holds while refused
  // ------------------------------------------------------------
  assign nxt = idx + 13'(src_byte_out.valid && src_ready_in);

  always @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      idx <= 13'h1000;
      hole <= 1'b0;
      src_byte_out <= '0;
    end else if (start_in) begin
      idx <= 13'h0;
      src_byte_out <= {1'b1, mem[0]};
    end else if (!src_byte_out.valid || src_ready_in) begin
      idx <= nxt;
      hole <= gap_in && !hole;
      if (nxt < 13'h1000 && !(gap_in && !hole))
        src_byte_out <= {1'b1, mem[nxt[11:0]]};
      else
        src_byte_out <= {1'b0, ~src_byte_out.data}; // released line keeps toggling
    end
  end
endmodule : spcrc_src_model

// File: verification/tb_top.sv
// bench for the scratchpad checker: sectors, error flags, stalls
`timescale 1ns/1ps
module tb_top
  import spcrc_pkg::*;
;
  localparam spcrc_ver_t V = 32'h0a0b0c0d;
  localparam logic [31:0] SZ = 32'h00000ff4;
  logic clock_in = 1'b0;
  logic resetn_in = 1'b0;
  logic start = 1'b0, gap = 1'b0, sig_bad = 1'b0, user_ready_in = 1'b1;
  logic [7:0] blk = 8'h00;
  logic [31:0] size = 32'h00000ff4, crc_mask = 32'h0;
  logic [1:0] sel_block_in = 2'h0;
  spcrc_ver_t ver = V, exp_ver_in = V;
  spcrc_byte_t src_byte, user_byte;
  logic src_ready, busy, done, sel_match;
  spcrc_flags_t flags;
  logic [7:0] block_num;
  logic [11:0] uoff = 12'h010;
  int failures = 0, num_checks = 0, cycles = 0;

  always #4 clock_in = ~clock_in;

  spcrc_checker dut (.clock_in(clock_in), .resetn_in(resetn_in), .src_byte_in(src_byte),
    .src_ready_out(src_ready), .exp_ver_in(exp_ver_in), .sel_block_in(sel_block_in),
    .user_byte_out(user_byte), .user_ready_in(user_ready_in), .busy_out(busy), .done_out(done),
    .flags_out(flags), .block_num_out(block_num), .sel_match_out(sel_match));

  spcrc_src_model src (.clock_in(clock_in), .resetn_in(resetn_in), .start_in(start), .gap_in(gap),
    .blk_in(blk), .sig_bad_in(sig_bad), .size_in(size), .ver_in(ver), .crc_mask_in(crc_mask),
    .src_byte_out(src_byte), .src_ready_in(src_ready));

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic finish_test();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  // user bytes must come out unaltered, in address order
  always @(posedge clock_in) begin
    if (user_byte.valid && user_ready_in) begin
      check(32'(user_byte.data), 32'(uoff < 12'h100 ? uoff[7:0] : 8'hff), "user byte");
      uoff <= (uoff == 12'hfff) ? 12'h010 : uoff + 12'h1;
    end
    cycles++;
    if (cycles == 80000) begin
      failures++;
      finish_test();
    end
  end

  // ------------------------------------------------------------
  // one sector through the checker
  // ------------------------------------------------------------
  task automatic run_block(input logic [7:0] b, input logic [1:0] s, input logic sb, input logic [31:0] sz,
      input spcrc_ver_t ev, input logic [31:0] m, input spcrc_flags_t ef, input logic em, input logic st);
    int n;
    blk = b;
    sel_block_in = s;
    sig_bad = sb;
    size = sz;
    exp_ver_in = ev;
    crc_mask = m;
    gap = st;
    user_ready_in = !st;
    start = 1'b1;
    @(posedge clock_in);
    #1;
    start = 1'b0;
    if (st) begin
      repeat (300) @(posedge clock_in);
      #1;
      check(32'(src_ready), 32'h0, "fifo full refuses");
      check(32'({user_byte.valid, user_byte.data}), 32'h110, "held user byte");
      user_ready_in = 1'b1;
    end
    n = 0;
    while (done !== 1'b1 && n < 20000) begin
      if (n == 100)
        check(32'(busy), 32'h1, "busy mid block");
      @(posedge clock_in);
      #1;
      n++;
    end
    check(32'(done), 32'h1, "done seen");
    check(32'(busy), 32'h0, "busy after done");
    check(32'(flags), 32'(ef), "flags");
    check(32'(block_num), 32'(b), "block number");
    check(32'(sel_match), 32'(em), "select match");
    @(posedge clock_in);
    #1;
    check(32'(done), 32'h0, "done one cycle");
    check(32'(flags), 32'(ef), "flags held");
    check(32'(uoff), 32'h010, "user byte count");
  endtask : run_block

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_good();
    run_block(8'h00, 2'h0, 1'b0, SZ, V, 32'h0, 5'h00, 1'b1, 1'b0);
    run_block(8'h03, 2'h3, 1'b0, SZ, V, 32'h0, 5'h00, 1'b1, 1'b0);
    run_block(8'h02, 2'h1, 1'b0, SZ, V, 32'h0, 5'h00, 1'b0, 1'b0);
  endtask : t_good

  task automatic t_header();
    run_block(8'h01, 2'h1, 1'b1, SZ, V, 32'h0, 5'h10, 1'b1, 1'b0);
    run_block(8'h01, 2'h1, 1'b0, 32'h00000ff5, V, 32'h0, 5'h08, 1'b1, 1'b0);
    run_block(8'h01, 2'h1, 1'b0, 32'hf40f0000, V, 32'h0, 5'h08, 1'b1, 1'b0);
    run_block(8'h04, 2'h1, 1'b0, SZ, V, 32'h0, 5'h04, 1'b0, 1'b0);
  endtask : t_header

  task automatic t_version();
    run_block(8'h01, 2'h1, 1'b0, SZ, V ^ 32'h00000001, 32'h0, 5'h02, 1'b1, 1'b0);
    run_block(8'h01, 2'h1, 1'b0, SZ, V ^ 32'h00000100, 32'h0, 5'h02, 1'b1, 1'b0);
    run_block(8'h01, 2'h1, 1'b0, SZ, V ^ 32'h00010000, 32'h0, 5'h02, 1'b1, 1'b0);
  endtask : t_version

  task automatic t_crc();
    run_block(8'h02, 2'h2, 1'b0, SZ, V, 32'h80000000, 5'h01, 1'b1, 1'b0);
  endtask : t_crc

  // gappy source and a stalled consumer fill the fifo until it refuses
  task automatic t_stall();
    run_block(8'h03, 2'h3, 1'b0, SZ, V, 32'h0, 5'h00, 1'b1, 1'b1);
  endtask : t_stall

  initial begin
    repeat (8) @(posedge clock_in);
    #1;
    resetn_in = 1'b1;
    t_good();
    t_header();
    t_version();
    t_crc();
    t_stall();
    finish_test();
  end
endmodule : tb_top
